// file: rtl/ssr_defines.svh
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
`define SSR_STOP_MODE_CODE 8'h08
`define SSR_STOP_CLEAR_MASK 16'h0000
`define SSR_MEM_DEPTH 64
`define SSR_MEM_WIDTH 8
`define SSR_PORT_W 3
`endif

// file: rtl/ssr_pkg.sv
package ssr_pkg;
	typedef enum logic [2:0] {
		SSR_BOOT,
		SSR_RESTORE,
		SSR_IDLE,
		SSR_SAVE,
		SSR_CLEAR
	} ssr_state_t;
endpackage

// file: rtl/ssr_sequencer.sv
`include "ssr_defines.svh"
module ssr_sequencer import ssr_pkg::*; #(
	parameter int DEPTH = `SSR_MEM_DEPTH,
	parameter int WIDTH = `SSR_MEM_WIDTH,
	parameter int PW = `SSR_PORT_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// host command strobes, one cycle each
	input wire logic stop_cmd,
	input wire logic [7:0] stop_mode,
	input wire logic [15:0] stop_mask,
	input wire logic backup_cmd,
	input wire logic clear_cmd,
	input wire logic [PW-1:0] cmd_port,
	// device status inputs
	input wire logic time_valid_in,
	input wire logic [2**PW-1:0] port_filter_ok,
	// backed state memory side
	output logic mem_rd,
	output logic [$clog2(DEPTH)-1:0] mem_addr,
	input wire logic [WIDTH-1:0] mem_rdata,
	output logic mem_wr,
	output logic [WIDTH-1:0] mem_wdata,
	// external flash side
	output logic fl_wr,
	output logic fl_rd,
	output logic fl_erase,
	output logic [$clog2(DEPTH)-1:0] fl_addr,
	output logic [WIDTH-1:0] fl_wdata,
	input wire logic [WIDTH-1:0] fl_rdata,
	input wire logic fl_image_present,
	input wire logic fl_ok,
	// reports to host
	output logic result_report,
	output logic result_ok,
	output logic restore_report,
	output logic [PW-1:0] report_port,
	output logic notice_restored,
	output logic ack_pos,
	output logic ack_neg,
	output logic time_unknown,
	output logic boot_done
);
	localparam int AW = $clog2(DEPTH);
	// the end marker is the top counter bit, so only a power-of-two depth can be served
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1 || PW < 1) begin : g_bad_params
		$error("ssr_sequencer: unsupported parameters");
	end

	// sequence overview: after reset the flash is asked once whether it holds an image;
	// if so, every word is copied back into the backed memory before commands are served.
	// a save copies the other way, word for word, and is answered by a single report.
	// a copy takes DEPTH cycles plus three to drain; backup and clear commands that arrive meanwhile
	// are dropped (a stop still updates the stop flag), since the host is expected to wait for the report.
	ssr_state_t state; // sequencer state
	logic [AW:0] cnt; // word counter, one spare bit marks the end
	logic stopped; // a proper stop command was seen
	logic [PW-1:0] saved_port; // port that carried the backup command
	// two pipe stages: one for the registered read strobe, one for the far side's
	// registered read data; a single stage would copy the word of the cycle before
	logic pipe; // read strobe issued this cycle
	logic [AW-1:0] pipe_addr; // address of that read
	logic pipe2; // read data for the earlier strobe stands at the input now
	logic [AW-1:0] pipe2_addr; // address that data belongs to
	logic save_err; // a flash write failed during this save

	// copy finished: every read issued and both pipe stages empty
	function automatic logic drained(input logic [AW:0] c, input logic p1, input logic p2);
		return c[AW] && !p1 && !p2;
	endfunction

	// stop must use controlled-stop mode with nothing cleared, else state is lost
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			stopped <= 1'b0;
		else if (stop_cmd)
			stopped <= (stop_mode == `SSR_STOP_MODE_CODE) && (stop_mask == `SSR_STOP_CLEAR_MASK);
		// a restored image starts a new session, so the host must stop again
		else if (state == SSR_RESTORE)
			stopped <= 1'b0;
	end

	// main sequencer; a copy runs one word per cycle, both directions alike
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= SSR_BOOT;
			cnt <= '0;
			pipe <= 1'b0;
			pipe_addr <= '0;
			pipe2 <= 1'b0;
			pipe2_addr <= '0;
			save_err <= 1'b0;
			saved_port <= '0;
		end else begin
			// pipe is raised only while reads are issued; pipe2 trails it by one cycle
			pipe <= 1'b0;
			pipe2 <= pipe;
			pipe2_addr <= pipe_addr;
			case (state)
				SSR_BOOT: begin
					cnt <= '0;
					// restore on image presence alone, age is never checked
					state <= fl_image_present ? SSR_RESTORE : SSR_IDLE;
				end
				SSR_RESTORE: begin
					// flash to backed memory, word i to address i
					pipe <= ~cnt[AW];
					pipe_addr <= cnt[AW-1:0];
					if (!cnt[AW]) begin
						cnt <= cnt + 1'b1;
					end else if (drained(cnt, pipe, pipe2)) begin
						// the last write has been issued; leave only now
						state <= SSR_IDLE;
					end
				end
				SSR_IDLE: begin
					cnt <= '0;
					save_err <= 1'b0;
					// save starts only on a host command, and only after a valid stop
					if (backup_cmd && stopped) begin
						saved_port <= cmd_port;
						state <= SSR_SAVE;
					end else if (clear_cmd) begin
						// a valid (stopped) backup wins when both arrive together; an unstopped one loses to clear
						state <= SSR_CLEAR;
					end
				end
				SSR_SAVE: begin
					// backed memory to flash, word i to address i
					pipe <= ~cnt[AW];
					pipe_addr <= cnt[AW-1:0];
					// any refused flash write spoils the whole image
					if (fl_wr && !fl_ok)
						save_err <= 1'b1;
					if (!cnt[AW]) begin
						cnt <= cnt + 1'b1;
					end else if (drained(cnt, pipe, pipe2)) begin
						state <= SSR_IDLE;
					end
				end
				// erase was issued on entry; the answer follows in the next cycle
				SSR_CLEAR: state <= SSR_IDLE;
				default: state <= SSR_IDLE;
			endcase
		end
	end

	// memory and flash strobes; a read goes out with cnt, its word is written two cycles later
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			fl_rd <= 1'b0;
			fl_wr <= 1'b0;
			fl_addr <= '0;
			fl_wdata <= '0;
			fl_erase <= 1'b0;
		end else begin
			// reads: the source side of the copy is addressed by the counter
			mem_rd <= (state == SSR_SAVE) && !cnt[AW];
			fl_rd <= (state == SSR_RESTORE) && !cnt[AW];
			// writes: the sink side takes the word that the read two cycles back returned
			mem_wr <= (state == SSR_RESTORE) && pipe2;
			fl_wr <= (state == SSR_SAVE) && pipe2;
			// each side is only read or only written during one copy, never both
			mem_addr <= (state == SSR_RESTORE) ? pipe2_addr : cnt[AW-1:0];
			fl_addr <= (state == SSR_SAVE) ? pipe2_addr : cnt[AW-1:0];
			// data passes through unchanged; the write strobe picks the right cycle
			mem_wdata <= fl_rdata;
			fl_wdata <= mem_rdata;
			// erase only on the clear command; an invalid backup never touches flash
			fl_erase <= (state == SSR_IDLE) && clear_cmd && !(backup_cmd && stopped);
		end
	end

	// reports back to the host, each a one-cycle pulse except report_port, which holds saved_port
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			result_report <= 1'b0;
			result_ok <= 1'b0;
			restore_report <= 1'b0;
			notice_restored <= 1'b0;
			report_port <= '0;
			ack_pos <= 1'b0;
			ack_neg <= 1'b0;
		end else begin
			// only a valid (stopped) backup gets a result report, at the end of the copy
			result_report <= (state == SSR_SAVE) && drained(cnt, pipe, pipe2);
			// success needs every write and the final flash status to be good
			result_ok <= (state == SSR_SAVE) && drained(cnt, pipe, pipe2) && !save_err
				&& fl_ok;
			// no image means the restore state is never entered, so nothing is sent
			restore_report <= (state == SSR_RESTORE) && drained(cnt, pipe, pipe2)
				&& port_filter_ok[saved_port];
			// the notice goes to the boot output whatever the report filter says
			notice_restored <= (state == SSR_RESTORE) && drained(cnt, pipe, pipe2);
			// limitation: the port is not kept over a power cycle, so a report after
			// power-up names port 0 unless a backup happened in this session
			report_port <= saved_port;
			ack_pos <= (state == SSR_CLEAR) && fl_ok;
			ack_neg <= (state == SSR_CLEAR) && !fl_ok;
		end
	end

	// time knowledge: never carried in the image, so unknown after any boot
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			time_unknown <= 1'b1;
			boot_done <= 1'b0;
		end else begin
			// the image may carry stale time, so it is never trusted while booting
			if (state == SSR_RESTORE || state == SSR_BOOT)
				time_unknown <= 1'b1;
			// afterwards only the device's own time source can make time known again
			else
				time_unknown <= !time_valid_in;
			// commands are served once the copy back from flash is over
			boot_done <= (state != SSR_BOOT) && (state != SSR_RESTORE);
		end
	end
endmodule // ssr_sequencer

// file: tb/ssr_part_model.sv
module ssr_part_model #(parameter int D = 4) (
	// memory and flash side
	input wire logic ref_clk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [$clog2(D)-1:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	input wire logic fl_wr,
	input wire logic fl_rd,
	input wire logic fl_erase,
	input wire logic [$clog2(D)-1:0] fl_addr,
	input wire logic [7:0] fl_wdata,
	output logic [7:0] fl_rdata,
	output logic fl_image_present
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [D]; // backed state memory
	logic [7:0] fl [D]; // flash survives a design reset, like a power cycle
	initial fl_image_present = 1'b0;
	// released read lines flip so a stale value never passes
	always @(posedge ref_clk) begin
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
		fl_rdata <= fl_rd ? fl[fl_addr] : ~fl_rdata;
		if (mem_wr) mem[mem_addr] <= mem_wdata;
		if (fl_wr) fl[fl_addr] <= fl_wdata;
		if (fl_wr) fl_image_present <= 1'b1;
		if (fl_erase) fl_image_present <= 1'b0;
	end
endmodule // ssr_part_model

// file: tb/ssr_sequencer_sva.sv
module ssr_sequencer_sva #(parameter int PW = 3) (
	// watched ports
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clear_cmd,
	input wire logic [2**PW-1:0] port_filter_ok,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic fl_rd,
	input wire logic fl_wr,
	input wire logic result_report,
	input wire logic restore_report,
	input wire logic [PW-1:0] report_port,
	input wire logic notice_restored,
	input wire logic ack_pos,
	input wire logic ack_neg,
	input wire logic time_unknown,
	input wire logic boot_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// one word moving each way
	sequence save_s; mem_rd ##2 fl_wr; endsequence
	sequence load_s; fl_rd ##2 mem_wr; endsequence
	save_word_a: assert property (mem_rd |-> save_s) else $error("no flash write");
	load_word_a: assert property (fl_rd |-> load_s) else $error("no memory write");
	time_lost_a: assert property (mem_wr |-> time_unknown) else $error("time kept");
	boot_no_save_a: assert property (!boot_done |-> !fl_wr) else $error("early save");
	report_once_a: assert property (result_report |=> !result_report) else $error("long");
	restore_ok_a: assert property (restore_report |-> notice_restored &&
		port_filter_ok[report_port]) else $error("bad restore report");
	clear_ack_a: assert property (ack_pos || ack_neg |-> $past(clear_cmd, 2))
		else $error("stray ack");
	ack_single_a: assert property (!(ack_pos && ack_neg)) else $error("both acks");
	boot_time_a: assert property (!boot_done |-> time_unknown) else $error("time kept");
endmodule // ssr_sequencer_sva
bind ssr_sequencer ssr_sequencer_sva #(.PW(PW)) u_sva (.ref_clk, .arst_n, .clear_cmd,
	.port_filter_ok, .mem_rd, .mem_wr, .fl_rd, .fl_wr, .result_report, .restore_report,
	.report_port, .notice_restored, .ack_pos, .ack_neg, .time_unknown, .boot_done);

// file: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, arst_n, stop_cmd, backup_cmd, clear_cmd, time_valid_in, fl_ok;
	logic [7:0] stop_mode, port_filter_ok, mem_rdata, mem_wdata, fl_rdata, fl_wdata;
	logic [15:0] stop_mask;
	logic [2:0] cmd_port, report_port;
	logic [1:0] mem_addr, fl_addr;
	logic mem_rd, mem_wr, fl_wr, fl_rd, fl_erase, fl_image_present, result_ok, ok_seen, pos_seen;
	logic result_report, restore_report, notice_restored, ack_pos, ack_neg, time_unknown, boot_done;
	int fails, n_tests, n_res, n_rest, n_note, n_ack, n_up;
	ssr_sequencer #(.DEPTH(4)) i_ssr_sequencer (.ref_clk, .arst_n, .stop_cmd, .stop_mode,
		.stop_mask, .backup_cmd, .clear_cmd, .cmd_port, .time_valid_in, .port_filter_ok, .mem_rd,
		.mem_addr, .mem_rdata, .mem_wr, .mem_wdata, .fl_wr, .fl_rd, .fl_erase, .fl_addr, .fl_wdata,
		.fl_rdata, .fl_image_present, .fl_ok, .result_report, .result_ok, .restore_report,
		.report_port, .notice_restored, .ack_pos, .ack_neg, .time_unknown, .boot_done);
	ssr_part_model u_part (.ref_clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .fl_wr,
		.fl_rd, .fl_erase, .fl_addr, .fl_wdata, .fl_rdata, .fl_image_present);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// pulse counters, so one-cycle reports are never missed
	always @(posedge ref_clk) begin
		n_res += result_report;
		n_rest += restore_report;
		n_note += notice_restored;
		n_ack += ack_pos | ack_neg;
		n_up += boot_done;
		if (result_report) ok_seen = result_ok;
		if (ack_pos | ack_neg) pos_seen = ack_pos;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_cnt(ref int c, input int v);
		for (int i = 0; c < v; i++) begin
			if (i == 60) begin
				fails++;
				report_and_stop();
			end
			@(posedge ref_clk);
		end
	endtask
	task automatic do_reset;
		arst_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		{n_res, n_rest, n_note, n_ack, n_up} = '0;
		arst_n <= 1'b1;
		wait_cnt(n_up, 1);
	endtask
	// one-cycle command strobes
	task automatic cmd(input logic s, input logic b, input logic c);
		@(posedge ref_clk);
		{stop_cmd, backup_cmd, clear_cmd} <= {s, b, c};
		@(posedge ref_clk);
		{stop_cmd, backup_cmd, clear_cmd} <= 3'h0;
	endtask
	task automatic t_refused;
		repeat (10) @(posedge ref_clk);
		chk(n_rest + n_note, 0);
		cmd(1'b1, 1'b0, 1'b0);
		cmd(1'b0, 1'b1, 1'b0);
		repeat (30) @(posedge ref_clk);
		chk(n_res, 0);
		chk(fl_image_present, 1'b0);
	endtask
	task automatic t_save;
		for (int i = 0; i < 4; i++) u_part.mem[i] = 8'h5a + i;
		time_valid_in <= 1'b1;
		stop_mode <= 8'h08;
		cmd(1'b1, 1'b0, 1'b0);
		chk(time_unknown, 1'b0);
		// a good save, then one whose flash writes fail
		for (int k = 0; k < 2; k++) begin
			fl_ok <= (k == 0);
			cmd(1'b0, 1'b1, 1'b0);
			wait_cnt(n_res, k + 1);
			@(posedge ref_clk);
			chk(ok_seen, k == 0);
		end
		fl_ok <= 1'b1;
		for (int i = 0; i < 4; i++) chk(u_part.fl[i], 8'h5a + i);
	endtask
	task automatic t_restore;
		// first power-up with the report filtered off on port 0, then allowed
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 4; i++) u_part.mem[i] = 8'h00;
			port_filter_ok <= k ? 8'hff : 8'hfe;
			time_valid_in <= 1'b0;
			do_reset();
			repeat (3) @(posedge ref_clk);
			chk(n_rest, k);
			chk(n_note, 1);
			chk(time_unknown, 1'b1);
			for (int i = 0; i < 4; i++) chk(u_part.mem[i], 8'h5a + i);
		end
		time_valid_in <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(time_unknown, 1'b0);
		cmd(1'b0, 1'b0, 1'b1);
		wait_cnt(n_ack, 1);
		@(posedge ref_clk);
		chk(pos_seen, 1'b1);
		chk(fl_image_present, 1'b0);
		fl_ok <= 1'b0;
		cmd(1'b0, 1'b0, 1'b1);
		wait_cnt(n_ack, 2);
		@(posedge ref_clk);
		chk(pos_seen, 1'b0);
	endtask
	initial begin
		{arst_n, stop_cmd, backup_cmd, clear_cmd, time_valid_in} = '0;
		{stop_mode, stop_mask, cmd_port} = {8'h01, 16'h0000, 3'h0};
		port_filter_ok = 8'hff;
		fl_ok = 1'b1;
		do_reset();
		t_refused();
		t_save();
		t_restore();
		report_and_stop();
	end
endmodule // testbench
